// ===== include/dsl_pkg.sv
// Purpose: Shared constants and types for the drive status LED indicator.
// Assumes: 100 MHz hclk, AHB-Lite register access with 32-bit data.
// Notes: Offsets are byte addresses; all registers are one aligned word.
package dsl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned DSL_CLK_HZ = 100_000_000;
    localparam int unsigned DSL_SLOW_HALF_MS = 1000;   // 0.5 Hz blink
    localparam int unsigned DSL_FAST_HALF_MS = 250;    // 2 Hz blink
    localparam int unsigned DSL_START_MS = 1000;       // Orange start-up hold
    localparam int unsigned DSL_SLOW_HALF_CYC = DSL_SLOW_HALF_MS * (DSL_CLK_HZ / 1000);
    localparam int unsigned DSL_FAST_HALF_CYC = DSL_FAST_HALF_MS * (DSL_CLK_HZ / 1000);
    localparam int unsigned DSL_START_CYC = DSL_START_MS * (DSL_CLK_HZ / 1000);
    localparam int unsigned DSL_PWR_CYCLES = 3;        // Power cycles for recovery fault

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] DSL_ADDR_CTRL = 12'h000;
    localparam logic [11:0] DSL_ADDR_STATE = 12'h004;
    localparam logic [11:0] DSL_ADDR_FAULT_NUM = 12'h008;
    localparam logic [11:0] DSL_ADDR_IRQ_STAT = 12'h00C;
    localparam logic [11:0] DSL_ADDR_IRQ_MASK = 12'h010;
    localparam logic [11:0] DSL_ADDR_LED = 12'h014;

    // Control register bit positions
    localparam int DSL_CTRL_BUS_EN = 0;      // 0: fieldbus unused
    localparam int DSL_CTRL_BUS_DP = 1;      // 1: DP, 0: RS485
    localparam int DSL_CTRL_SAFE_EN = 2;
    localparam int DSL_CTRL_UNRESP = 3;      // Drive found unresponsive
    localparam logic [31:0] DSL_CTRL_RESET = 32'h0000_0000;

    // Interrupt status bit positions
    localparam int DSL_IRQ_READY = 0;        // Start-up interval over
    localparam int DSL_IRQ_FAULT = 1;        // Fault rose
    localparam int DSL_IRQ_SAFE_FLT = 2;     // Safety fault rose
    localparam int DSL_IRQ_RECOV = 3;        // Recovery fault raised
    localparam int DSL_IRQ_W = 4;

    localparam logic [15:0] DSL_FNUM_NONE = 16'h0000;

    // ------------------------------------------------------------------
    // LED encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {DSL_COL_OFF, DSL_COL_GREEN, DSL_COL_RED, DSL_COL_ORANGE} dsl_col_t;
    typedef enum logic [1:0] {DSL_PAT_ON, DSL_PAT_SLOW, DSL_PAT_FAST} dsl_pat_t;

    typedef struct packed {
        dsl_col_t col;
        dsl_pat_t pat;
    } dsl_led_t;

    // Inverter status inputs
    typedef struct packed {
        logic ready;
        logic commissioning;
        logic fw_busy;
        logic fw_done;
        logic fw_failed;
        logic fw_incompat;
        logic fault;
        logic [15:0] fault_num;
    } dsl_drv_t;

    // Fieldbus status inputs
    typedef struct packed {
        logic proc_data;
        logic bus_active;
        logic cfg_fault;
    } dsl_bus_t;

    // Safety status inputs
    typedef struct packed {
        logic enabled;
        logic active;
        logic fault;
    } dsl_safe_t;

endpackage

// ===== logic/dsl_led_indicator.sv
// Purpose: Drive status LED indicator with AHB-Lite register slave.
// Assumes: Status inputs come from logic on hclk; the power-cycle count
//          arrives from an always-on domain and is synchronised here.
// Notes: Outputs are registered LED on/off levels per colour.
//
// The placing of the registers and the AHB-Lite register port are this design's own decisions.

// Behaviour
// R1: Ready LED orange during start-up interval
// R2: State display only after start-up ends
// R3: Ready steady green when ready, no fault
// R4: Ready green slow during commissioning or factory reset
// R5: Firmware update: ready red, bus dark
// R6: Update done: ready and bus red slow
// R7: General fault red fast; update failure bus red
// R8: Incompatible firmware: both red fast
// R9: RS485 bus: dark, slow, fast by activity
// R10: DP bus dark on exchange or unused
// R11: DP config fault slow, no exchange fast
// R12: Safety yellow steady when enabled, inactive
// R13: Safety yellow slow while active, no fault
// R14: Safety fault: safety yellow fast
// R15: Fault number reported readable
// R16: Three power cycles when unresponsive raise recovery
// R17: Recovery fault cleared only by power cycle
// R18: Prescaler makes distinct slow, fast blinks
// R19: Ready priority: update errors, fault, commissioning, ready
module dsl_led_indicator #(
    parameter int unsigned SLOW_HALF_CYC = dsl_pkg::DSL_SLOW_HALF_CYC,
    parameter int unsigned FAST_HALF_CYC = dsl_pkg::DSL_FAST_HALF_CYC,
    parameter int unsigned START_CYC = dsl_pkg::DSL_START_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire dsl_pkg::dsl_drv_t drv,
    input wire dsl_pkg::dsl_bus_t bus,
    input wire dsl_pkg::dsl_safe_t safe,
    input wire logic [1:0] pwr_cycle_count,
    output logic ready_red,
    output logic ready_green,
    output logic bus_indicator_red,
    output logic safe_yellow,
    output logic irq
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // Turns colour and pattern into a lit level for the present blink phases
    function automatic logic led_lit(input dsl_pkg::dsl_led_t l, input logic slow_ph,
                                     input logic fast_ph);
        led_lit = 1'b0;
        if (l.col != dsl_pkg::DSL_COL_OFF) begin
            led_lit = l.pat == dsl_pkg::DSL_PAT_ON ||
                      (l.pat == dsl_pkg::DSL_PAT_SLOW && slow_ph) ||
                      (l.pat == dsl_pkg::DSL_PAT_FAST && fast_ph);
        end
    endfunction

    function automatic dsl_pkg::dsl_led_t mk(input dsl_pkg::dsl_col_t c,
                                              input dsl_pkg::dsl_pat_t p);
        mk.col = c;
        mk.pat = p;
    endfunction

    // ------------------------------------------------------------------
    // Blink prescaler
    // ------------------------------------------------------------------
    logic [31:0] slow_cnt;
    logic [31:0] fast_cnt;
    logic slow_ph;
    logic fast_ph;

    // Two free counters; each toggles its phase at its half period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_cnt <= 32'h0000_0000;
            fast_cnt <= 32'h0000_0000;
            slow_ph <= 1'b0;
            fast_ph <= 1'b0;
        end else begin
            if (slow_cnt >= SLOW_HALF_CYC - 1) begin // [R18]
                slow_cnt <= 32'h0000_0000;
                slow_ph <= ~slow_ph;
            end else begin
                slow_cnt <= slow_cnt + 32'h0000_0001;
            end
            if (fast_cnt >= FAST_HALF_CYC - 1) begin // [R18]
                fast_cnt <= 32'h0000_0000;
                fast_ph <= ~fast_ph;
            end else begin
                fast_cnt <= fast_cnt + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Start-up interval
    // ------------------------------------------------------------------
    logic [31:0] start_cnt;
    logic started;

    // Orange is held until the counter expires, then state display begins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            start_cnt <= 32'h0000_0000;
            started <= 1'b0;
        end else if (!started) begin
            if (start_cnt >= START_CYC - 1) begin
                started <= 1'b1; // [R1]
            end else begin
                start_cnt <= start_cnt + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power-cycle count synchroniser and recovery fault
    // ------------------------------------------------------------------
    logic [1:0] pwr_meta;
    logic [1:0] pwr_sync;
    logic recovery_fault;
    logic [31:0] ctrl;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwr_meta <= 2'b00;
            pwr_sync <= 2'b00;
        end else begin
            pwr_meta <= pwr_cycle_count;
            pwr_sync <= pwr_meta;
        end
    end

    // Only hresetn (the power cycle) clears it; no bus write reaches it,
    // so software acknowledgement cannot hide a stuck drive.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            recovery_fault <= 1'b0; // [R17]
        end else if (ctrl[dsl_pkg::DSL_CTRL_UNRESP] &&
                     32'(pwr_sync) >= dsl_pkg::DSL_PWR_CYCLES) begin
            recovery_fault <= 1'b1; // [R16]
        end
    end

    // ------------------------------------------------------------------
    // Indicator selection
    // ------------------------------------------------------------------
    dsl_pkg::dsl_led_t rdy_sel;
    dsl_pkg::dsl_led_t bus_sel;
    dsl_pkg::dsl_led_t saf_sel;
    logic any_fault;
    // Dark selection shared by every idle branch
    localparam dsl_pkg::dsl_led_t LED_DARK = '{col: dsl_pkg::DSL_COL_OFF,
                                               pat: dsl_pkg::DSL_PAT_ON};

    assign any_fault = drv.fault | recovery_fault;

    // Ready LED in priority order; update errors above general faults
    always_comb begin
        if (!started) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_ORANGE, dsl_pkg::DSL_PAT_ON); // [R1]
        end else if (drv.fw_incompat || drv.fw_failed) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_FAST); // [R8] [R7] [R19]
        end else if (drv.fw_busy) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_ON); // [R5]
        end else if (drv.fw_done) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_SLOW); // [R6]
        end else if (any_fault) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_FAST); // [R7] [R19]
        end else if (drv.commissioning) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_GREEN, dsl_pkg::DSL_PAT_SLOW); // [R4] [R19]
        end else if (drv.ready) begin
            rdy_sel = mk(dsl_pkg::DSL_COL_GREEN, dsl_pkg::DSL_PAT_ON); // [R3]
        end else begin
            rdy_sel = LED_DARK;
        end
    end

    // Bus LED: firmware states override the fieldbus diagnostics
    always_comb begin
        if (!started) begin
            bus_sel = LED_DARK; // [R2]
        end else if (drv.fw_incompat) begin
            bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_FAST); // [R8]
        end else if (drv.fw_failed) begin
            bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_ON); // [R7]
        end else if (drv.fw_busy) begin
            bus_sel = LED_DARK; // [R5]
        end else if (drv.fw_done) begin
            bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_SLOW); // [R6]
        // Data exchange in either mode, or no fieldbus at all: nothing to report
        end else if (!ctrl[dsl_pkg::DSL_CTRL_BUS_EN] || bus.proc_data) begin
            bus_sel = LED_DARK; // [R9] [R10]
        end else if (ctrl[dsl_pkg::DSL_CTRL_BUS_DP]) begin
            if (bus.cfg_fault) begin
                bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_SLOW); // [R11]
            end else begin
                bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_FAST); // [R11]
            end
        end else begin
            if (bus.bus_active) begin
                bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_SLOW); // [R9]
            end else begin
                bus_sel = mk(dsl_pkg::DSL_COL_RED, dsl_pkg::DSL_PAT_FAST); // [R9]
            end
        end
    end

    // Safety LED uses orange code as yellow; fault outranks active
    always_comb begin
        if (!started || !ctrl[dsl_pkg::DSL_CTRL_SAFE_EN]) begin
            saf_sel = LED_DARK; // [R2]
        end else if (safe.fault) begin
            saf_sel = mk(dsl_pkg::DSL_COL_ORANGE, dsl_pkg::DSL_PAT_FAST); // [R14]
        end else if (safe.active) begin
            saf_sel = mk(dsl_pkg::DSL_COL_ORANGE, dsl_pkg::DSL_PAT_SLOW); // [R13]
        end else if (safe.enabled) begin
            saf_sel = mk(dsl_pkg::DSL_COL_ORANGE, dsl_pkg::DSL_PAT_ON); // [R12]
        end else begin
            saf_sel = LED_DARK;
        end
    end

    // Registered LED drive; orange lights both ready dies
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_red <= 1'b0;
            ready_green <= 1'b0;
            bus_indicator_red <= 1'b0;
            safe_yellow <= 1'b0;
        end else begin
            ready_red <= led_lit(rdy_sel, slow_ph, fast_ph) &&
                         (rdy_sel.col != dsl_pkg::DSL_COL_GREEN);
            ready_green <= led_lit(rdy_sel, slow_ph, fast_ph) &&
                           (rdy_sel.col != dsl_pkg::DSL_COL_RED);
            bus_indicator_red <= led_lit(bus_sel, slow_ph, fast_ph);
            safe_yellow <= led_lit(saf_sel, slow_ph, fast_ph);
        end
    end

    // ------------------------------------------------------------------
    // Fault number capture
    // ------------------------------------------------------------------
    logic [15:0] fault_num;

    // Latest nonzero number seen while drv.fault is set is kept for the panel, tool and master to read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_num <= dsl_pkg::DSL_FNUM_NONE;
        end else if (drv.fault && drv.fault_num != dsl_pkg::DSL_FNUM_NONE) begin
            fault_num <= drv.fault_num; // [R15]
        end
    end

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    logic [dsl_pkg::DSL_IRQ_W-1:0] ev_prev;
    logic [dsl_pkg::DSL_IRQ_W-1:0] ev_now;
    logic [dsl_pkg::DSL_IRQ_W-1:0] irq_stat;
    logic [dsl_pkg::DSL_IRQ_W-1:0] irq_mask;
    logic stat_rd;

    assign ev_now = {recovery_fault, safe.fault, any_fault, started};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ev_prev <= '0;
        end else begin
            ev_prev <= ev_now;
        end
    end

    // Rising edges set sticky bits; a read clears only the bits it returned
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (stat_rd ? irq_stat & ~hrdata[dsl_pkg::DSL_IRQ_W-1:0] : irq_stat) |
                        (ev_now & ~ev_prev);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic dp_valid;
    logic dp_write;
    logic [11:0] dp_addr;

    // Zero wait states: address phase captured, data phase acts at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= 12'h000;
        end else if (hready) begin
            dp_valid <= hsel && htrans[1];
            dp_write <= hwrite;
            dp_addr <= haddr[11:0];
        end
    end

    assign stat_rd = dp_valid && !dp_write && dp_addr == dsl_pkg::DSL_ADDR_IRQ_STAT;

    // Writable registers; other offsets ignore writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= dsl_pkg::DSL_CTRL_RESET;
            irq_mask <= '0;
        end else if (dp_valid && dp_write) begin
            if (dp_addr == dsl_pkg::DSL_ADDR_CTRL) begin
                ctrl <= hwdata;
            end
            if (dp_addr == dsl_pkg::DSL_ADDR_IRQ_MASK) begin
                irq_mask <= hwdata[dsl_pkg::DSL_IRQ_W-1:0];
            end
        end
    end

    logic [31:0] next_hrdata;

    // Read mux; unmapped offsets read zero with OKAY
    always_comb begin
        next_hrdata = 32'h0000_0000;
        unique case (haddr[11:0])
            dsl_pkg::DSL_ADDR_CTRL: next_hrdata = ctrl;
            dsl_pkg::DSL_ADDR_STATE: next_hrdata = {26'h000_0000, recovery_fault,
                                                    started, slow_ph, fast_ph,
                                                    any_fault, safe.fault};
            dsl_pkg::DSL_ADDR_FAULT_NUM: next_hrdata = {16'h0000, fault_num}; // [R15]
            dsl_pkg::DSL_ADDR_IRQ_STAT: next_hrdata = {28'h000_0000, irq_stat};
            dsl_pkg::DSL_ADDR_IRQ_MASK: next_hrdata = {28'h000_0000, irq_mask};
            dsl_pkg::DSL_ADDR_LED: next_hrdata = {26'h000_0000, rdy_sel.col, bus_sel.pat,
                                                  saf_sel.pat};
            default: next_hrdata = 32'h0000_0000;
        endcase
    end

    // Read data registered at the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= next_hrdata;
            end
        end
    end

endmodule

// ===== tb/dsl_led_indicator_props.sv
// Purpose: Concurrent checks on the status LED indicator ports.
// Assumes: One hclk domain; status inputs held for several cycles.
// Notes: Conditions need three or four steady cycles to cover output lag.
module dsl_led_props #(
    parameter int unsigned START_CYC = 20
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire dsl_pkg::dsl_drv_t drv,
    input wire logic [1:0] pwr_cycle_count,
    input wire logic ready_red,
    input wire logic ready_green,
    input wire logic bus_indicator_red,
    input wire logic safe_yellow
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned cnt;
    logic up, busy_c, done_c, flt_c, rdy_c, rd_bad, fw_any;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Cycles since reset release, saturating so it never wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
        end else if (cnt < START_CYC + 4) begin
            cnt <= cnt + 1;
        end
    end

    // Status conditions; a held power-cycle count may mean recovery fault
    assign up = cnt > START_CYC + 1;
    assign fw_any = drv.fw_busy || drv.fw_done || drv.fw_failed || drv.fw_incompat;
    assign busy_c = drv.fw_busy && !drv.fw_failed && !drv.fw_incompat;
    assign done_c = drv.fw_incompat || (drv.fw_done && !drv.fw_busy && !drv.fw_failed);
    assign flt_c = drv.fault && !fw_any;
    assign rdy_c = drv.ready && !drv.commissioning && !drv.fault && !fw_any
        && pwr_cycle_count != 2'h3;
    assign rd_bad = hsel && htrans[1] && hready && !hwrite && haddr[11:0] > 12'h014;

    sequence s_busy;
        up ##0 busy_c [*3];
    endsequence
    sequence s_flt;
        up ##0 flt_c [*4];
    endsequence

    a_orange_start: assert property (cnt >= 2 && cnt < START_CYC |-> ready_red && ready_green)
        else $error("ready LED not orange in start-up");
    a_dark_start: assert property (cnt >= 2 && cnt < START_CYC |-> !bus_indicator_red && !safe_yellow)
        else $error("bus or safety LED lit in start-up");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or erred");
    a_busy_red: assert property (s_busy |-> ready_red && !ready_green && !bus_indicator_red)
        else $error("update display wrong");
    a_green_ready: assert property (up ##0 rdy_c [*3] |-> ready_green && !ready_red)
        else $error("ready display not steady green");
    a_fw_both: assert property (up ##0 done_c [*3] |-> !ready_green && ready_red == bus_indicator_red)
        else $error("ready and bus LEDs not blinking together");
    a_fault_blink: assert property (s_flt ##0 $changed(ready_red) ##1 flt_c [*2]
        |-> $past(ready_red) == $past(ready_red, 2) && $changed(ready_red))
        else $error("fault blink half period wrong");
    a_unmapped_zero: assert property (rd_bad |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
endmodule

bind dsl_led_indicator dsl_led_props #(.START_CYC(START_CYC)) u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
    .hresp, .drv, .pwr_cycle_count, .ready_red, .ready_green, .bus_indicator_red,
    .safe_yellow
);

// ===== tb/dsl_led_indicator_bench.sv
// Purpose: Self-checking bench for the status LED indicator.
// Assumes: Short start-up and blink counts; hready looped from hreadyout.
// Notes: LED patterns are classified by counting level changes in 40 cycles.
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("FAIL %s expected %h seen %h", n, e, g); end end
module dsl_led_indicator_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned ST = 20;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h0000_005A;
    logic [1:0] htrans = 0, pwr = 0;
    logic ready_red, ready_green, bus_indicator_red, safe_yellow;
    wire logic [3:0] leds = {ready_red, ready_green, bus_indicator_red, safe_yellow};
    logic [7:0] got;
    dsl_pkg::dsl_drv_t drv = '0;
    dsl_pkg::dsl_bus_t bus = '0;
    dsl_pkg::dsl_safe_t safe = '0;
    int n_mismatch = 0, samples_checked = 0;
    // {flags ready..fault, bus, safe, ctrl, expect red/green/bus/safe: 0 on 1 slow 2 fast 3 off}
    logic [23:0] tbl [16] = '{
        24'h80_00CF, 24'hC0_00DF, 24'hA2_003F, 24'h10_0077,
        24'hC2_00BF, 24'h08_00B3, 24'h24_00BB, 24'h81_81CF,
        24'h80_81C7, 24'h80_01CB, 24'h81_03CF, 24'h80_43C7,
        24'h80_03CB, 24'h80_24CC, 24'h80_34CD, 24'h80_3CCE};

    dsl_led_indicator #(.SLOW_HALF_CYC(8), .FAST_HALF_CYC(2), .START_CYC(ST)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .drv, .bus, .safe,
        .pwr_cycle_count(pwr), .ready_red, .ready_green, .bus_indicator_red, .safe_yellow,
        .irq);

    // ----------------------------------------
    // Clock, helpers and bus tasks
    // ----------------------------------------
    initial forever #5 hclk = ~hclk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic give_verdict();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One single AHB transfer; waits on hready rather than assuming timing
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk_rd(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(n, e, rd)
    endtask

    task automatic chk_recov(input string n, input logic e);
        xfer(1'b0, dsl_pkg::DSL_ADDR_STATE, 32'h0000_0000);
        `CHK(n, e, rd[5])
    endtask

    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 0;
        pwr <= 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1;
    endtask

    // Few changes mean slow blink, many mean fast; none means steady or dark
    task automatic observe(output logic [7:0] g);
        logic [3:0] last;
        logic [3:0] now;
        int ch [4];
        ch = '{default: 0};
        repeat (4) @(posedge hclk);
        #1 last = leds;
        repeat (40) begin
            @(posedge hclk);
            #1 now = leds;
            for (int i = 0; i < 4; i++) ch[i] += int'(now[i] != last[i]);
            last = now;
        end
        for (int i = 0; i < 4; i++) begin
            g[2*i+:2] = ch[i] == 0 ? (last[i] ? 2'h0 : 2'h3) : (ch[i] < 10 ? 2'h1 : 2'h2);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        xfer(1'b0, dsl_pkg::DSL_ADDR_LED, 32'h0000_0000);
        `CHK("led_start", 2'h3, rd[5:4])
        chk_rd("ctrl_rst", dsl_pkg::DSL_ADDR_CTRL, 32'h0000_0000);
        chk_rd("mask_rst", dsl_pkg::DSL_ADDR_IRQ_MASK, 32'h0000_0000);
        repeat (ST) @(posedge hclk);
        chk_rd("stat_up", dsl_pkg::DSL_ADDR_IRQ_STAT, 32'h0000_0001);
        chk_rd("stat_clr", dsl_pkg::DSL_ADDR_IRQ_STAT, 32'h0000_0000);
        xfer(1'b1, dsl_pkg::DSL_ADDR_IRQ_MASK, 32'h0000_0002);
        drv.fault <= 1;
        repeat (3) @(posedge hclk);
        `CHK("irq_on", 1'b1, irq)
        chk_rd("stat_flt", dsl_pkg::DSL_ADDR_IRQ_STAT, 32'h0000_0002);
        repeat (2) @(posedge hclk);
        `CHK("irq_off", 1'b0, irq)
        xfer(1'b1, dsl_pkg::DSL_ADDR_IRQ_MASK, 32'h0000_0000);
        drv.fault <= 0;
        repeat (2) @(posedge hclk);
        drv.fault <= 1;
        repeat (3) @(posedge hclk);
        `CHK("irq_masked", 1'b0, irq)
        chk_rd("stat_masked", dsl_pkg::DSL_ADDR_IRQ_STAT, 32'h0000_0002);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            drv <= {tbl[i][23:17], seed[15:0]};
            bus <= tbl[i][16:14];
            safe <= tbl[i][13:11];
            xfer(1'b1, dsl_pkg::DSL_ADDR_CTRL, {29'h0000_0000, tbl[i][10:8]});
            observe(got);
            `CHK("led_pattern", tbl[i][7:0], got)
        end
        repeat (4) begin
            seed = xs(seed);
            drv <= {7'b0000001, seed[15:0] | 16'h0001};
            repeat (2) @(posedge hclk);
            chk_rd("fault_num", dsl_pkg::DSL_ADDR_FAULT_NUM, {16'h0000, seed[15:0] | 16'h0001});
            xfer(1'b1, dsl_pkg::DSL_ADDR_IRQ_MASK, seed);
            chk_rd("mask_rw", dsl_pkg::DSL_ADDR_IRQ_MASK, {28'h000_0000, seed[3:0]});
        end
        xfer(1'b1, 12'h018, 32'hFFFF_FFFF);
        chk_rd("unmapped", 12'h018, 32'h0000_0000);
        chk_rd("ctrl_keep", dsl_pkg::DSL_ADDR_CTRL, 32'h0000_0004);
        drv <= {7'b1000000, 16'h0000};
        xfer(1'b1, dsl_pkg::DSL_ADDR_CTRL, 32'h0000_0008);
        pwr <= 2;
        repeat (4) @(posedge hclk);
        chk_recov("recov_two", 1'b0);
        pwr <= 3;
        repeat (4) @(posedge hclk);
        chk_recov("recov_three", 1'b1);
        xfer(1'b1, dsl_pkg::DSL_ADDR_CTRL, 32'h0000_0000);
        chk_recov("recov_sticky", 1'b1);
        observe(got);
        `CHK("recov_led", 4'hB, got[7:4])
        do_reset();
        repeat (ST + 4) @(posedge hclk);
        chk_recov("recov_clear", 1'b0);
        give_verdict();
    end

    // Watchdog well beyond the thousand or so cycles the sequence needs
    initial begin
        #200_000;
        n_mismatch++;
        give_verdict();
    end
endmodule
